/* File: core/predriver_pkg.sv */
package predriver_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int RST_LATENCY_NS  = 77;
  // longest time: round down
  localparam int RST_LATENCY_CYC = RST_LATENCY_NS / CLK_PERIOD_NS;
  localparam int DEAD_NS         = 100;
  // least time: round up
  localparam int DEAD_CYC        = (DEAD_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

  // serial frame layout
  localparam int FRAME_BITS = 8;
  localparam int OP_MSB     = 7;
  localparam int OP_LSB     = 4;
  localparam int DATA_MSB   = 3;
  localparam int DATA_LSB   = 0;

  // fault sources and mask split
  localparam int FAULT_W    = 8;
  localparam int MASK_W     = 4;
  localparam int PHASES     = 3;

  // config bits
  localparam int CFG_W           = 2;
  localparam int CFG_DT_OVR_BIT  = 0;
  localparam int CFG_ILK_OVR_BIT = 1;

  // reset values
  localparam logic [MASK_W-1:0]  MASK_RST  = 4'h0;
  localparam logic [CFG_W-1:0]   CFG_RST   = 2'h0;
  localparam logic [FAULT_W-1:0] FAULT_RST = 8'h00;

  // serial command opcodes
  typedef enum logic [3:0] {
    OP_STATUS    = 4'b0000,
    OP_MASK_LOW  = 4'b0010,
    OP_MASK_HIGH = 4'b0011,
    OP_CONFIG    = 4'b0100,
    OP_CLR_IRQ   = 4'b0110
  } spi_op_t;

endpackage : predriver_pkg

/* File: core/spi_frame_port.sv */
`timescale 1ns/1ps

module spi_frame_port
  import predriver_pkg::*;
#(
  parameter int FRAME_W = FRAME_BITS
) (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  input  wire logic               sclk_i,
  input  wire logic               cs_n_i,
  input  wire logic               sdi_i,
  input  wire logic [FRAME_W-1:0] tx_data_i,
  output logic      [FRAME_W-1:0] rx_data_o,
  output logic                    rx_valid_o,
  output logic                    sdo_o,
  output logic                    sdo_oe_o
);

  localparam int CW = $clog2(FRAME_W + 1);
  localparam logic [CW-1:0] LAST_BIT = CW'(FRAME_W - 1);

  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic sdi_s1, sdi_s2;
  logic sclk_rise, sclk_fall, cs_fall, active;
  logic [CW-1:0]      bit_cnt_r;
  logic [FRAME_W-1:0] rx_sh_r;
  logic [FRAME_W-1:0] tx_sh_r;

  // two-stage synchronisers, third stage for edges
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1   <= 1'b1;
      cs_s2   <= 1'b1;
      cs_s3   <= 1'b1;
      sdi_s1  <= 1'b0;
      sdi_s2  <= 1'b0;
    end else begin
      sclk_s1 <= sclk_i;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1   <= cs_n_i;
      cs_s2   <= cs_s1;
      cs_s3   <= cs_s2;
      sdi_s1  <= sdi_i;
      sdi_s2  <= sdi_s1;
    end
  end

  // edge and frame decode
  assign sclk_rise = sclk_s2 & ~sclk_s3;
  assign sclk_fall = ~sclk_s2 & sclk_s3;
  assign cs_fall   = ~cs_s2 & cs_s3;
  assign active    = ~cs_s2;

  // receive: sample on falling edge, msb first
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bit_cnt_r  <= '0;
      rx_sh_r    <= '0;
      rx_data_o  <= '0;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (!active) begin
        bit_cnt_r <= '0;
      end else if (sclk_fall) begin
        rx_sh_r <= {rx_sh_r[FRAME_W-2:0], sdi_s2};
        if (bit_cnt_r == LAST_BIT) begin
          rx_data_o  <= {rx_sh_r[FRAME_W-2:0], sdi_s2};
          rx_valid_o <= 1'b1;
          bit_cnt_r  <= '0;
        end else begin
          bit_cnt_r <= bit_cnt_r + CW'(1);
        end
      end
    end
  end

  // transmit: load at frame start, change on rising edge
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
      tx_sh_r  <= '0;
    end else begin
      sdo_oe_o <= active;
      if (cs_fall) begin
        sdo_o   <= tx_data_i[FRAME_W-1];
        tx_sh_r <= tx_data_i;
      end else if (active && sclk_rise) begin
        sdo_o   <= tx_sh_r[FRAME_W-1];
        tx_sh_r <= {tx_sh_r[FRAME_W-2:0], 1'b0};
      end else if (!active) begin
        sdo_o <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sdo_release_a: assert property (cs_s2 |=> !sdo_oe_o)
    else $error("serial output driven with select high");

  sdo_edge_a: assert property (
    $changed(sdo_o) && $past(active) && !$past(cs_fall)
      |-> $past(sclk_rise))
    else $error("serial output changed off a rising edge");

  rx_fall_a: assert property (rx_valid_o |-> $past(sclk_fall))
    else $error("frame completed without a falling edge");

endmodule : spi_frame_port

/* File: core/three_phase_predriver_control.sv */
`timescale 1ns/1ps

// Overview of operation
// - gates drive only with both enables high
// - enable low clears gates without clock
// - high side waits for low side pulse
// - reset pin low: bias off, weak pulldown
// - logic reset within 77 ns of pin
// - power-on: reset held, gates hi-z, serial off
// - interrupt stays high until clear command
// - one bit of the low or high mask gates each fault source
// - serial frames only with select low
// - serial input sampled falling edge, msb first
// - serial output driven only with select low
// - serial output changes on rising edge
// - high-side commands active low, default off
// - low-side commands active high, default off
// - phase status follows comparator level
// - overcurrent status follows comparator level
// - deadtime and interlock, each overridable
module three_phase_predriver_control
  import predriver_pkg::*;
#(
  parameter int DEAD_COUNT = DEAD_CYC
) (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  input  wire logic               reset_n_i,
  input  wire logic               power_good_i,
  input  wire logic               enable_first_i,
  input  wire logic               enable_second_i,
  input  wire logic               phase_a_high_cmd_n_i,
  input  wire logic               phase_a_low_cmd_i,
  input  wire logic               phase_b_high_cmd_n_i,
  input  wire logic               phase_b_low_cmd_i,
  input  wire logic               phase_c_high_cmd_n_i,
  input  wire logic               phase_c_low_cmd_i,
  input  wire logic               phase_a_cmp_i,
  input  wire logic               phase_b_cmp_i,
  input  wire logic               phase_c_cmp_i,
  input  wire logic               overcurrent_cmp_i,
  input  wire logic [FAULT_W-1:0] fault_i,
  input  wire logic               sclk_i,
  input  wire logic               cs_n_i,
  input  wire logic               sdi_i,
  output logic                    sdo_o,
  output logic                    sdo_oe_o,
  output logic      [PHASES-1:0]  high_gate_o,
  output logic      [PHASES-1:0]  low_gate_o,
  output logic                    gate_oe_o,
  output logic                    gate_pulldown_o,
  output logic                    bias_on_o,
  output logic                    irq_o,
  output logic                    phase_a_level_out_o,
  output logic                    phase_b_level_out_o,
  output logic                    phase_c_level_out_o,
  output logic                    overcurrent_flag_out_o
);

  localparam int DW = $clog2(DEAD_COUNT + 1);
  localparam logic [DW-1:0] DEAD_LOAD = DW'(DEAD_COUNT);

  // decides whether one driver of a phase may be on next cycle
  function automatic logic drive_next(
    input logic req,
    input logic other_req,
    input logic own_on,
    input logic other_on,
    input logic idle,
    input logic ilk_ovr,
    input logic dt_ovr
  );
    logic clear;
    clear      = dt_ovr | (idle & ~other_on);
    drive_next = req & (ilk_ovr | ~other_req) & (own_on | clear);
  endfunction : drive_next

  logic                en_pins;
  logic                en_s1, en_s2;
  logic                rstn_s1, rstn_s2;
  logic                por_s1, por_s2;
  logic                int_rst_r;
  logic [PHASES-1:0]   hs_raw, ls_raw;
  logic [PHASES-1:0]   hs_s1, hs_s2, ls_s1, ls_s2;
  logic [PHASES-1:0]   cmp_raw, cmp_s1, cmp_s2;
  logic                oc_s1, oc_s2;
  logic [FAULT_W-1:0]  fault_s1, fault_s2;
  logic [PHASES-1:0]   hs_req, ls_req;
  logic [PHASES-1:0]   hs_nxt, ls_nxt;
  logic [PHASES-1:0]   boot_ok_r;
  logic [DW-1:0]       dead_cnt_r [PHASES];
  logic [MASK_W-1:0]   fault_mask_low_r;
  logic [MASK_W-1:0]   fault_mask_high_r;
  logic [CFG_W-1:0]    cfg_r;
  logic [FAULT_W-1:0]  fault_lat_r;
  logic [FAULT_W-1:0]  mask_all;
  logic [FAULT_W-1:0]  unmasked;
  logic [FRAME_BITS-1:0] rx_data;
  logic                rx_valid;
  logic                clr_irq;
  spi_op_t             rx_op;

  // pin bundles
  assign en_pins = enable_first_i & enable_second_i;
  assign hs_raw  = {phase_c_high_cmd_n_i, phase_b_high_cmd_n_i,
                    phase_a_high_cmd_n_i};
  assign ls_raw  = {phase_c_low_cmd_i, phase_b_low_cmd_i,
                    phase_a_low_cmd_i};
  assign cmp_raw = {phase_c_cmp_i, phase_b_cmp_i, phase_a_cmp_i};

  // synchronisers for reset, power-good and enables
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rstn_s1 <= 1'b0;
      rstn_s2 <= 1'b0;
      por_s1  <= 1'b0;
      por_s2  <= 1'b0;
      en_s1   <= 1'b0;
      en_s2   <= 1'b0;
    end else begin
      rstn_s1 <= reset_n_i;
      rstn_s2 <= rstn_s1;
      por_s1  <= power_good_i;
      por_s2  <= por_s1;
      en_s1   <= en_pins;
      en_s2   <= en_s1;
    end
  end

  // synchronisers for commands, comparators and faults
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      hs_s1    <= '1;
      hs_s2    <= '1;
      ls_s1    <= '0;
      ls_s2    <= '0;
      cmp_s1   <= '0;
      cmp_s2   <= '0;
      oc_s1    <= 1'b0;
      oc_s2    <= 1'b0;
      fault_s1 <= '0;
      fault_s2 <= '0;
    end else begin
      hs_s1    <= hs_raw;
      hs_s2    <= hs_s1;
      ls_s1    <= ls_raw;
      ls_s2    <= ls_s1;
      cmp_s1   <= cmp_raw;
      cmp_s2   <= cmp_s1;
      oc_s1    <= overcurrent_cmp_i;
      oc_s2    <= oc_s1;
      fault_s1 <= fault_i;
      fault_s2 <= fault_s1;
    end
  end

  // internal reset from reset pin and power-on
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      int_rst_r <= 1'b1;
    end else begin
      int_rst_r <= ~rstn_s2 | ~por_s2;
    end
  end

  // supply-state outputs
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gate_oe_o       <= 1'b0;
      gate_pulldown_o <= 1'b1;
      bias_on_o       <= 1'b0;
    end else begin
      gate_oe_o       <= por_s2 & rstn_s2;
      gate_pulldown_o <= ~rstn_s2;
      bias_on_o       <= rstn_s2 & por_s2;
    end
  end

  // command decode: high active low, low active high
  assign hs_req = ~hs_s2;
  assign ls_req = ls_s2;

  // per-phase gate decision
  always_comb begin
    for (int i = 0; i < PHASES; i++) begin
      hs_nxt[i] = en_s2 & boot_ok_r[i] &
                  drive_next(hs_req[i], ls_req[i], high_gate_o[i],
                             low_gate_o[i], dead_cnt_r[i] == '0,
                             cfg_r[CFG_ILK_OVR_BIT],
                             cfg_r[CFG_DT_OVR_BIT]);
      ls_nxt[i] = en_s2 &
                  drive_next(ls_req[i], hs_req[i], low_gate_o[i],
                             high_gate_o[i], dead_cnt_r[i] == '0,
                             cfg_r[CFG_ILK_OVR_BIT],
                             cfg_r[CFG_DT_OVR_BIT]);
    end
  end

  // gate flops, cleared at once by either enable low
  always_ff @(posedge clock_i or negedge en_pins) begin
    if (!en_pins) begin
      high_gate_o <= '0;
      low_gate_o  <= '0;
    end else if (rst_i || int_rst_r) begin
      high_gate_o <= '0;
      low_gate_o  <= '0;
    end else begin
      high_gate_o <= hs_nxt;
      low_gate_o  <= ls_nxt;
    end
  end

  // bootstrap charged once low side has been on
  always_ff @(posedge clock_i) begin
    if (rst_i || int_rst_r) begin
      boot_ok_r <= '0;
    end else begin
      for (int i = 0; i < PHASES; i++) begin
        if (low_gate_o[i]) begin
          boot_ok_r[i] <= 1'b1;
        end else if (!en_s2) begin
          boot_ok_r[i] <= 1'b0;
        end
      end
    end
  end

  // deadtime: held full while a gate is on, counts after
  always_ff @(posedge clock_i) begin
    if (rst_i || int_rst_r) begin
      for (int i = 0; i < PHASES; i++) begin
        dead_cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < PHASES; i++) begin
        if (high_gate_o[i] || low_gate_o[i]) begin
          dead_cnt_r[i] <= DEAD_LOAD;
        end else if (dead_cnt_r[i] != '0) begin
          dead_cnt_r[i] <= dead_cnt_r[i] - DW'(1);
        end
      end
    end
  end

  // status outputs follow comparators
  always_ff @(posedge clock_i) begin
    if (rst_i || int_rst_r) begin
      phase_a_level_out_o    <= 1'b0;
      phase_b_level_out_o    <= 1'b0;
      phase_c_level_out_o    <= 1'b0;
      overcurrent_flag_out_o <= 1'b0;
    end else begin
      phase_a_level_out_o    <= cmp_s2[0];
      phase_b_level_out_o    <= cmp_s2[1];
      phase_c_level_out_o    <= cmp_s2[2];
      overcurrent_flag_out_o <= oc_s2;
    end
  end

  // serial port, held in reset with the core
  spi_frame_port #(
    .FRAME_W   (FRAME_BITS)
  ) u_spi (
    .clock_i   (clock_i),
    .rst_i     (rst_i | int_rst_r),
    .sclk_i    (sclk_i),
    .cs_n_i    (cs_n_i),
    .sdi_i     (sdi_i),
    .tx_data_i (fault_lat_r),
    .rx_data_o (rx_data),
    .rx_valid_o(rx_valid),
    .sdo_o     (sdo_o),
    .sdo_oe_o  (sdo_oe_o)
  );

  assign rx_op = spi_op_t'(rx_data[OP_MSB:OP_LSB]);
  assign clr_irq = rx_valid && (rx_op == OP_CLR_IRQ);

  // command execution
  always_ff @(posedge clock_i) begin
    if (rst_i || int_rst_r) begin
      fault_mask_low_r  <= MASK_RST;
      fault_mask_high_r <= MASK_RST;
      cfg_r             <= CFG_RST;
    end else if (rx_valid) begin
      case (rx_op)
        OP_MASK_LOW:  fault_mask_low_r  <= rx_data[DATA_MSB:DATA_LSB];
        OP_MASK_HIGH: fault_mask_high_r <= rx_data[DATA_MSB:DATA_LSB];
        OP_CONFIG:    cfg_r <= rx_data[CFG_W-1:DATA_LSB];
        default: begin
          cfg_r <= cfg_r;
        end
      endcase
    end
  end

  // masks gate faults onto the interrupt
  assign mask_all = {fault_mask_high_r, fault_mask_low_r};
  assign unmasked = fault_s2 & ~mask_all;

  // latched faults and interrupt, set wins over clear
  always_ff @(posedge clock_i) begin
    if (rst_i || int_rst_r) begin
      fault_lat_r <= FAULT_RST;
      irq_o       <= 1'b0;
    end else begin
      fault_lat_r <= (clr_irq ? FAULT_RST : fault_lat_r) | fault_s2;
      if (|unmasked) begin
        irq_o <= 1'b1;
      end else if (clr_irq) begin
        irq_o <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  localparam int RstBound = RST_LATENCY_CYC - 2; // two cycles in sequence
  sequence pin_reset_held;
    $fell(reset_n_i) ##1 (!reset_n_i) [*2];
  endsequence
  sequence fault_unmasked;
    |unmasked;
  endsequence
  gates_enable_a: assert property (
    !en_pins |-> (high_gate_o == '0 && low_gate_o == '0))
    else $error("gate on while an enable is low");
  boot_first_a: assert property (
    (high_gate_o & ~boot_ok_r) == '0)
    else $error("high side on before low side pulse");
  reset_latency_a: assert property (
    pin_reset_held |-> ##[0:RstBound] int_rst_r)
    else $error("logic not reset in time after pin");
  pulldown_held_a: assert property (
    !rstn_s2 |=> (gate_pulldown_o && !bias_on_o) ##1 (high_gate_o == '0))
    else $error("reset pin low without low-power state");
  por_hiz_a: assert property (
    !por_s2 |=> (!gate_oe_o && int_rst_r) ##1 !sdo_oe_o)
    else $error("outputs active before power-on release");
  irq_hold_a: assert property (
    irq_o && !clr_irq && !int_rst_r |=> irq_o)
    else $error("interrupt dropped without clear");
  irq_cause_a: assert property (
    $rose(irq_o) |-> $past(|unmasked))
    else $error("interrupt rose from a masked fault");
  irq_raise_a: assert property (
    fault_unmasked ##1 !int_rst_r |-> irq_o)
    else $error("unmasked fault did not raise interrupt");
  interlock_a: assert property (
    !cfg_r[CFG_ILK_OVR_BIT] && $past(!cfg_r[CFG_ILK_OVR_BIT])
      |-> (high_gate_o & low_gate_o) == '0)
    else $error("both drivers of a phase on together");
  both_req_off_a: assert property (
    en_pins && |(hs_req & ls_req) && !cfg_r[CFG_ILK_OVR_BIT]
      |=> ((high_gate_o | low_gate_o) & $past(hs_req & ls_req)) == '0)
    else $error("phase driven with both inputs requesting");
  level_follow_a: assert property (
    !int_rst_r |=> phase_a_level_out_o == $past(cmp_s2[0]))
    else $error("phase status does not follow comparator");
  oc_follow_a: assert property (
    !int_rst_r |=> overcurrent_flag_out_o == $past(oc_s2))
    else $error("overcurrent status does not follow comparator");

endmodule : three_phase_predriver_control

/* File: sim/mcu_model.sv */
`timescale 1ns/1ps

// controller side of the serial port, runs on its own 125 ns clock
module mcu_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  // idle levels follow the pin pulls
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end

  // one framed byte, msb first, clock still outside the frame
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    cs_n_o = 1'b0;
    #150;
    for (int b = 7; b >= 0; b--) begin
      sdi_o  = tx[b];
      sclk_o = 1'b1;
      #62.5;
      sclk_o = 1'b0;
      rx[b]  = sdo_i;
      #62.5;
    end
    #100;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
    #250;
  endtask : xfer
endmodule : mcu_model

/* File: sim/three_phase_predriver_control_tb.sv */
`timescale 1ns/1ps

module three_phase_predriver_control_tb;
  import predriver_pkg::*;
  localparam int DC = 4;
  localparam int GW = DC + 8;
  logic               clock_i = 1'b0;
  logic               rst_i   = 1'b1;
  logic               rst_n   = 1'b1;
  logic               pgood   = 1'b1;
  logic               en1     = 1'b0;
  logic               en2     = 1'b0;
  logic               oc      = 1'b0;
  logic [2:0]         hs_n    = 3'h7;
  logic [2:0]         ls      = 3'h0;
  logic [2:0]         cmpv    = 3'h0;
  logic [FAULT_W-1:0] flt     = 8'h00;
  logic [7:0]         rx;
  logic               sdo_line;
  wire logic          sclk, cs_n, sdi, sdo, sdo_oe, goe, gpd, bias, irq;
  wire logic [2:0]    hg, lg;
  wire logic [3:0]    lvl;
  int                 err_total = 0;
  int                 cmp_count = 0;

  always #2.5 clock_i = ~clock_i;
  // released line shows the inverse of sdo, which is cleared on release
  always_comb sdo_line = sdo_oe ? sdo : ~sdo;

  three_phase_predriver_control #(
    .DEAD_COUNT(DC)
  ) three_phase_predriver_control_i (
    .clock_i(clock_i), .rst_i(rst_i), .reset_n_i(rst_n),
    .power_good_i(pgood), .enable_first_i(en1), .enable_second_i(en2),
    .phase_a_high_cmd_n_i(hs_n[0]), .phase_a_low_cmd_i(ls[0]),
    .phase_b_high_cmd_n_i(hs_n[1]), .phase_b_low_cmd_i(ls[1]),
    .phase_c_high_cmd_n_i(hs_n[2]), .phase_c_low_cmd_i(ls[2]),
    .phase_a_cmp_i(cmpv[0]), .phase_b_cmp_i(cmpv[1]),
    .phase_c_cmp_i(cmpv[2]), .overcurrent_cmp_i(oc), .fault_i(flt),
    .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .high_gate_o(hg), .low_gate_o(lg),
    .gate_oe_o(goe), .gate_pulldown_o(gpd), .bias_on_o(bias),
    .irq_o(irq), .phase_a_level_out_o(lvl[0]),
    .phase_b_level_out_o(lvl[1]), .phase_c_level_out_o(lvl[2]),
    .overcurrent_flag_out_o(lvl[3]));

  mcu_model mcu_model_i (
    .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_line));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc

  task automatic spi(input logic [7:0] tx);
    cyc(1);
    mcu_model_i.xfer(tx, rx);
    cyc(6);
  endtask : spi

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // low-side pulse on all phases to arm the high sides
  task automatic pulse_low();
    @(posedge clock_i) ls <= 3'h7;
    cyc(GW);
    check(lg, 3'h7);
    @(posedge clock_i) ls <= 3'h0;
    cyc(GW);
    check(lg, 3'h0);
  endtask : pulse_low

  task automatic t_enable();
    @(posedge clock_i) {en1, en2} <= 2'b11;
    cyc(6);
    @(posedge clock_i) hs_n <= 3'h6;
    cyc(GW);
    check(hg, 3'h0);
    @(posedge clock_i) hs_n <= 3'h7;
    pulse_low();
    @(posedge clock_i) hs_n <= 3'h6;
    cyc(GW);
    check(hg, 3'h1);
    @(posedge clock_i) en1 <= 1'b0;
    #1 check(hg, 3'h0);
    cyc(3);
    @(posedge clock_i) en1 <= 1'b1;
    cyc(GW);
    check(hg, 3'h0);
    @(posedge clock_i) {hs_n, en2, ls} <= {3'h7, 1'b0, 3'h7};
    cyc(GW);
    check(lg, 3'h0);
    @(posedge clock_i) {en2, ls} <= {1'b1, 3'h0};
    cyc(6);
    pulse_low();
  endtask : t_enable

  task automatic t_interlock();
    @(posedge clock_i) {hs_n, ls} <= {3'h5, 3'h2};
    cyc(GW);
    check({hg, lg}, 6'h00);
    @(posedge clock_i) hs_n <= 3'h7;
    cyc(GW);
    check(lg, 3'h2);
    @(posedge clock_i) {hs_n, ls} <= {3'h5, 3'h0};
    cyc(4);
    check(hg, 3'h0);
    cyc(GW);
    check(hg, 3'h2);
    spi({OP_CONFIG, 4'h3});
    @(posedge clock_i) ls <= 3'h2;
    cyc(GW);
    check({hg[1], lg[1]}, 2'b11);
    @(posedge clock_i) {hs_n, ls} <= {3'h7, 3'h0};
    spi({OP_CONFIG, 4'h0});
  endtask : t_interlock

  task automatic t_irq();
    @(posedge clock_i) flt <= 8'h01;
    cyc(6);
    check(irq, 1'b1);
    @(posedge clock_i) flt <= 8'h00;
    cyc(6);
    check(irq, 1'b1);
    spi({OP_STATUS, 4'h0});
    check(rx & 8'h01, 8'h01);
    check(sdo_oe, 1'b0);
    spi({OP_CLR_IRQ, 4'h0});
    check(irq, 1'b0);
    spi({OP_MASK_LOW, 4'h1});
    spi({OP_MASK_HIGH, 4'h1});
    @(posedge clock_i) flt <= 8'h11;
    cyc(6);
    check(irq, 1'b0);
    @(posedge clock_i) flt <= 8'h20;
    cyc(6);
    check(irq, 1'b1);
    @(posedge clock_i) flt <= 8'h00;
    spi({OP_CLR_IRQ, 4'h0});
    spi({OP_MASK_HIGH, 4'h0});
    check(irq, 1'b0);
  endtask : t_irq

  task automatic t_levels();
    for (int i = 0; i < 16; i++) begin
      @(posedge clock_i) {oc, cmpv} <= 4'(i);
      cyc(5);
      check(lvl, 8'(i));
    end
  endtask : t_levels

  // mask low is still 0x1 from the interrupt test
  task automatic t_resetpin();
    @(posedge clock_i) rst_n <= 1'b0;
    cyc(RST_LATENCY_CYC);
    check({goe, bias, gpd, hg, lg}, 9'h040);
    @(posedge clock_i) rst_n <= 1'b1;
    cyc(6);
    @(posedge clock_i) flt <= 8'h01;
    cyc(6);
    check(irq, 1'b1);
    @(posedge clock_i) flt <= 8'h00;
    spi({OP_CLR_IRQ, 4'h0});
  endtask : t_resetpin

  task automatic t_por();
    @(posedge clock_i) pgood <= 1'b0;
    cyc(6);
    check({goe, bias, gpd}, 3'h0);
    spi({OP_MASK_LOW, 4'hF});
    check(sdo_oe, 1'b0);
    @(posedge clock_i) pgood <= 1'b1;
    cyc(6);
    check({goe, bias}, 2'b11);
    @(posedge clock_i) flt <= 8'h02;
    cyc(6);
    check(irq, 1'b1);
    @(posedge clock_i) flt <= 8'h00;
    spi({OP_CLR_IRQ, 4'h0});
  endtask : t_por

  // watchdog well past the expected run length
  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    cyc(5);
    check({goe, bias, gpd, irq, hg, lg}, 10'h300);
    check(sdo_oe, 1'b0);
    t_enable();
    t_interlock();
    t_irq();
    t_levels();
    t_resetpin();
    t_por();
    end_sim();
  end
endmodule : three_phase_predriver_control_tb
